/* rtl/adcs_pkg.sv */
// Purpose: shared constants for the converter setup register bank
// Assumes: 32-bit classic wishbone, one register per aligned word, 8 bits except the 4-bit analog field and the 16-bit result
// Notes:   offsets and reset values are fixed here only
`default_nettype none

package adcs_pkg;

	// ****************************************
	// bus shape
	// ****************************************
	localparam int WB_ADR_W = 8;
	localparam int WB_DAT_W = 32;
	localparam int REG_W    = 8;

	// ****************************************
	// register offsets (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_PORT1_DIR   = 8'h00;
	localparam logic [7:0] OFS_ANALOG_CFG  = 8'h04;
	localparam logic [7:0] OFS_PORT2_DIR   = 8'h08;
	localparam logic [7:0] OFS_CLK_GATE0   = 8'h0c;
	localparam logic [7:0] OFS_IRQ_MASK_H1 = 8'h10;
	localparam logic [7:0] OFS_IRQ_REQ_H1  = 8'h14;
	localparam logic [7:0] OFS_RESULT      = 8'h18;

	// ****************************************
	// reset values
	// ****************************************
	localparam logic [7:0] RST_PORT1_DIR   = 8'hff;
	localparam logic [3:0] RST_ANALOG_CFG  = 4'h1;
	localparam logic [7:0] RST_PORT2_DIR   = 8'hff;
	localparam logic [7:0] RST_CLK_GATE0   = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK_H1 = 8'hff;
	localparam logic [7:0] RST_IRQ_REQ_H1  = 8'h00;

	// ****************************************
	// fields
	// ****************************************
	localparam int CFG_W           = 4;
	localparam int CONV_CLK_EN_BIT = 5;
	localparam int CONV_IRQ_BIT    = 0;
	localparam int N_ANALOG        = 15;
	localparam int P2_ANALOG_PINS  = 4;
	localparam int RESULT_W        = 10;
	localparam int RESULT_SHIFT    = 6;
	localparam int RESULT_REG_W    = 16;

endpackage

`default_nettype wire

/* rtl/adcs_pin_decode.sv */
// Purpose: decode the analog pin configuration field into a per-input mask
// Assumes: field values 0 and 1 are the special cases
// Notes:   purely combinational, caller registers the result
`default_nettype none

module adcs_pin_decode
	import adcs_pkg::*;
#(
	parameter int N = N_ANALOG
) (
	input  wire logic [CFG_W-1:0] cfg_i,
	output logic      [N-1:0]     analog_o
);

	// refused at elaboration: the 4-bit field cannot reach more inputs
	if (N < 1 || N > 15) begin : g_bad_n
		$error("adcs_pin_decode: N must be 1 to 15");
	end

	// ****************************************
	// one compare per input
	// ****************************************
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_in
			localparam logic [CFG_W:0] LIMIT = (CFG_W+1)'(i + 2);
			// 0 selects all, 1 none, n keeps inputs 0..n-2 analog
			assign analog_o[i] = (cfg_i == '0) ? 1'b1 :
				({1'b0, cfg_i} >= LIMIT);
		end
	endgenerate

endmodule

`default_nettype wire

/* rtl/adcs_setup.sv */
// Purpose: converter pin, clock gate and end-of-conversion flag registers
// Assumes: converter core runs on clk_i; conv_done_i is a one-cycle pulse
// Notes:   all outputs lag the registers by one clock
//
// How it works
// - a port 1 direction bit of 0 drives the pin, 1 releases it as input.
// - the 4-bit field makes 0 all inputs analog, 1 none, n inputs 0..n-2.
// - port 2 pins 0..3 follow their direction bits, analog pins never drive.
// - bit 5 of the clock gate register feeds or stops the converter clock.
// - mask bit 0 blocks the conversion interrupt but not its flag.
// - request bit 0 reads 1 while a conversion end is pending, else 0.
// - the 10-bit result sits left-justified in a 16-bit register.
`default_nettype none

module adcs_setup
	import adcs_pkg::*;
(
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	input  wire logic                  cyc_i,
	input  wire logic                  stb_i,
	input  wire logic                  we_i,
	input  wire logic [WB_ADR_W-1:0]   adr_i,
	input  wire logic [3:0]            sel_i,
	input  wire logic [WB_DAT_W-1:0]   dat_i,
	output logic      [WB_DAT_W-1:0]   dat_o,
	output logic                       ack_o,
	input  wire logic                  conv_done_i,
	input  wire logic [RESULT_W-1:0]   conv_data_i,
	output logic      [REG_W-1:0]      port1_oe_n_o,
	output logic      [REG_W-1:0]      port2_oe_n_o,
	output logic      [N_ANALOG-1:0]   analog_sel_o,
	output logic                       conv_clk_en_o,
	output logic                       conv_irq_o
);

	if (RESULT_W + RESULT_SHIFT != RESULT_REG_W) begin : g_bad_result
		$error("adcs_setup: result does not fill its register");
	end

	// ****************************************
	// registers
	// ****************************************
	logic [REG_W-1:0]        port1_dir_reg;
	logic [CFG_W-1:0]        analog_cfg_reg;
	logic [REG_W-1:0]        port2_dir_reg;
	logic [REG_W-1:0]        clk_gate_reg;
	logic [REG_W-1:0]        irq_mask_reg;
	logic [REG_W-1:0]        irq_req_reg;
	logic [REG_W-1:0]        irq_req_next;
	logic [RESULT_REG_W-1:0] result_reg;
	logic [N_ANALOG-1:0]     analog_mask;
	logic                    req;
	logic                    wr;
	logic                    conv_event;

	assign req        = cyc_i & stb_i & ~ack_o;
	assign wr         = req & we_i & sel_i[0];
	assign conv_event = conv_done_i & clk_gate_reg[CONV_CLK_EN_BIT];

	adcs_pin_decode #(
		.N (N_ANALOG)
	) u_decode (
		.cfg_i    (analog_cfg_reg),
		.analog_o (analog_mask)
	);

	// ****************************************
	// bus slave
	// ****************************************
	// one wait state: ack follows the request by one edge, then drops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// unmapped offsets answer with zero and ignore writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_o <= '0;
		end else if (req && !we_i) begin
			case (adr_i)
				OFS_PORT1_DIR:   dat_o <= 32'(port1_dir_reg);
				OFS_ANALOG_CFG:  dat_o <= 32'(analog_cfg_reg);
				OFS_PORT2_DIR:   dat_o <= 32'(port2_dir_reg);
				OFS_CLK_GATE0:   dat_o <= 32'(clk_gate_reg);
				OFS_IRQ_MASK_H1: dat_o <= 32'(irq_mask_reg);
				OFS_IRQ_REQ_H1:  dat_o <= 32'(irq_req_reg);
				OFS_RESULT:      dat_o <= 32'(result_reg);
				default:         dat_o <= '0;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port1_dir_reg  <= RST_PORT1_DIR;
			analog_cfg_reg <= RST_ANALOG_CFG;
			port2_dir_reg  <= RST_PORT2_DIR;
			clk_gate_reg   <= RST_CLK_GATE0;
			irq_mask_reg   <= RST_IRQ_MASK_H1;
		end else if (wr) begin
			case (adr_i)
				OFS_PORT1_DIR:   port1_dir_reg  <= dat_i[REG_W-1:0];
				OFS_ANALOG_CFG:  analog_cfg_reg <= dat_i[CFG_W-1:0];
				OFS_PORT2_DIR:   port2_dir_reg  <= dat_i[REG_W-1:0];
				OFS_CLK_GATE0:   clk_gate_reg   <= dat_i[REG_W-1:0];
				OFS_IRQ_MASK_H1: irq_mask_reg   <= dat_i[REG_W-1:0];
				default:         port1_dir_reg  <= port1_dir_reg;
			endcase
		end
	end

	// ****************************************
	// conversion end flag and result
	// ****************************************
	// a conversion end in the same cycle as a software clear still sets
	always_comb begin
		irq_req_next = irq_req_reg;
		if (wr && adr_i == OFS_IRQ_REQ_H1) begin
			irq_req_next = dat_i[REG_W-1:0];
		end
		if (conv_event) begin
			irq_req_next[CONV_IRQ_BIT] = 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_reg <= RST_IRQ_REQ_H1;
		end else begin
			irq_req_reg <= irq_req_next;
		end
	end

	// no clock to the converter means no new result and no event
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			result_reg <= '0;
		end else if (conv_event) begin
			result_reg <= {conv_data_i, RESULT_SHIFT'(0)};
		end
	end

	// ****************************************
	// pin and converter outputs
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			port1_oe_n_o <= RST_PORT1_DIR;
			port2_oe_n_o <= RST_PORT2_DIR;
			analog_sel_o <= '0;
		end else begin
			port1_oe_n_o <= port1_dir_reg;
			// analog pins must never see the output buffer
			port2_oe_n_o <= port2_dir_reg |
				REG_W'(analog_mask[P2_ANALOG_PINS-1:0]);
			analog_sel_o <= analog_mask;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			conv_clk_en_o <= 1'b0;
			conv_irq_o    <= 1'b0;
		end else begin
			conv_clk_en_o <= clk_gate_reg[CONV_CLK_EN_BIT];
			conv_irq_o    <= irq_req_reg[CONV_IRQ_BIT] &
				~irq_mask_reg[CONV_IRQ_BIT];
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_port1_dir;
		@(posedge clk_i) disable iff (rst_i)
		wr && adr_i == OFS_PORT1_DIR |-> ##2 port1_oe_n_o == $past(dat_i[7:0], 2);
	endproperty
	a_port1_dir: assert property (p_port1_dir)
		else $error("port 1 enables do not follow a direction write");

	property p_none_analog;
		@(posedge clk_i) disable iff (rst_i)
		analog_cfg_reg == 4'h1 |=> analog_sel_o == '0;
	endproperty
	a_none_analog: assert property (p_none_analog)
		else $error("analog select set while configured for none");

	property p_cfg_five;
		@(posedge clk_i) disable iff (rst_i)
		analog_cfg_reg == 4'h5 |=> analog_sel_o == 15'h000f;
	endproperty
	a_cfg_five: assert property (p_cfg_five)
		else $error("config five must select inputs 0 to 3");

	property p_analog_no_drive;
		@(posedge clk_i) disable iff (rst_i)
		analog_mask[0] && !$past(rst_i) |=> port2_oe_n_o[0];
	endproperty
	a_analog_no_drive: assert property (p_analog_no_drive)
		else $error("analog port 2 pin is driven");

	property p_gated_no_event;
		@(posedge clk_i) disable iff (rst_i)
		conv_done_i && !clk_gate_reg[5] && !wr |=> $stable(result_reg);
	endproperty
	a_gated_no_event: assert property (p_gated_no_event)
		else $error("result changed with converter clock stopped");

	property p_masked_irq;
		@(posedge clk_i) disable iff (rst_i)
		irq_mask_reg[0] |=> !conv_irq_o;
	endproperty
	a_masked_irq: assert property (p_masked_irq)
		else $error("interrupt raised while masked");

	property p_flag_set;
		@(posedge clk_i) disable iff (rst_i)
		conv_done_i && clk_gate_reg[5] |=> irq_req_reg[0] ##1
			conv_irq_o == !$past(irq_mask_reg[0]);
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("conversion end did not set the request flag");

	property p_result_align;
		@(posedge clk_i) disable iff (rst_i)
		conv_event |=> result_reg[5:0] == 6'h00 &&
			result_reg[15:6] == $past(conv_data_i);
	endproperty
	a_result_align: assert property (p_result_align)
		else $error("result not left-justified");

endmodule

`default_nettype wire

/* test/adc_port_clock_irq_setup_tb.sv */
// Purpose: self-checking bench for the converter setup register bank
// Assumes: one-cycle ack, pin outputs lag register writes by one clock
// Notes:   expected values come from a small model kept in the bench
`default_nettype none

module adc_port_clock_irq_setup_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import adcs_pkg::*;

	// ****************************************
	// signals
	// ****************************************
	logic                clk_i       = 1'b0;
	logic                rst_i       = 1'b1;
	logic                cyc_i       = 1'b0;
	logic                stb_i       = 1'b0;
	logic                we_i        = 1'b0;
	logic [WB_ADR_W-1:0] adr_i       = '0;
	logic [3:0]          sel_i       = '0;
	logic [WB_DAT_W-1:0] dat_i       = '0;
	logic                conv_done_i = 1'b0;
	logic [RESULT_W-1:0] conv_data_i = '0;
	logic [WB_DAT_W-1:0] dat_o;
	logic                ack_o;
	logic [REG_W-1:0]    port1_oe_n_o;
	logic [REG_W-1:0]    port2_oe_n_o;
	logic [N_ANALOG-1:0] analog_sel_o;
	logic                conv_clk_en_o;
	logic                conv_irq_o;
	int                  n_errors = 0;
	int                  checks = 0;
	int                  cyc_cnt = 0;
	logic [31:0]         q;
	logic [31:0]         v;
	logic [9:0]          d;
	logic [N_ANALOG-1:0] m;
	logic [31:0]         rv [7];

	adcs_setup dut_u (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
		.stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
		.dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.conv_done_i(conv_done_i), .conv_data_i(conv_data_i),
		.port1_oe_n_o(port1_oe_n_o), .port2_oe_n_o(port2_oe_n_o),
		.analog_sel_o(analog_sel_o), .conv_clk_en_o(conv_clk_en_o),
		.conv_irq_o(conv_irq_o));

	// ****************************************
	// helpers
	// ****************************************
	initial begin
		forever #5 clk_i = ~clk_i;
	end

	task automatic final_report();
		$display("checks %0d errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// the whole run is under two hundred cycles, so this only cuts a hang
	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// entered just after a rising edge; returns one idle cycle after ack
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] wd, input logic [3:0] s);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= wd;
		sel_i <= s;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic ev(input logic [9:0] x);
		conv_done_i <= 1'b1;
		conv_data_i <= x;
		@(posedge clk_i);
		conv_done_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	function automatic logic [N_ANALOG-1:0] amask(input int n);
		if (n == 0) return '1;
		return N_ANALOG'((1 << (n - 1)) - 1);
	endfunction

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		void'($urandom(14044));
		rv = '{32'(RST_PORT1_DIR), 32'(RST_ANALOG_CFG), 32'(RST_PORT2_DIR),
			32'(RST_CLK_GATE0), 32'(RST_IRQ_MASK_H1), 32'(RST_IRQ_REQ_H1), 0};
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(32'(analog_sel_o), 0);
		for (int i = 0; i < 8; i++) begin
			bus(1'b0, 8'(i * 4), 0, 4'hf);
			chk(q, (i < 7) ? rv[i] : 0);
		end
		v = $urandom;
		bus(1'b1, OFS_PORT1_DIR, v, 4'h1);
		chk(32'(port1_oe_n_o), 32'(v[7:0]));
		bus(1'b1, OFS_PORT1_DIR, ~v, 4'h0);
		bus(1'b0, OFS_PORT1_DIR, 0, 4'hf);
		chk(q, 32'(v[7:0]));
		for (int n = 0; n < 16; n++) begin
			v = $urandom;
			bus(1'b1, OFS_ANALOG_CFG, n, 4'h1);
			bus(1'b1, OFS_PORT2_DIR, v, 4'h1);
			m = amask(n);
			chk(32'(analog_sel_o), 32'(m));
			chk(32'(port2_oe_n_o), {24'h0, v[7:4], v[3:0] | m[3:0]});
		end
		d = 10'($urandom);
		ev(d);
		chk(32'(conv_clk_en_o), 0);
		bus(1'b0, OFS_IRQ_REQ_H1, 0, 4'hf);
		chk(q, 0);
		bus(1'b1, OFS_CLK_GATE0, 32'h20, 4'h1);
		chk(32'(conv_clk_en_o), 1);
		ev(d);
		chk(32'(conv_irq_o), 0);
		bus(1'b0, OFS_IRQ_REQ_H1, 0, 4'hf);
		chk(q, 1);
		bus(1'b0, OFS_RESULT, 0, 4'hf);
		chk(q >> RESULT_SHIFT, 32'(d));
		bus(1'b1, OFS_IRQ_MASK_H1, 32'hfe, 4'h1);
		chk(32'(conv_irq_o), 1);
		bus(1'b1, OFS_IRQ_REQ_H1, 0, 4'h1);
		chk(32'(conv_irq_o), 0);
		bus(1'b0, OFS_IRQ_REQ_H1, 0, 4'hf);
		chk(q, 0);
		bus(1'b1, OFS_CLK_GATE0, 0, 4'h1);
		chk(32'(conv_clk_en_o), 0);
		final_report();
	end
endmodule

`default_nettype wire
